//--- pkg/lvd_defs.svh
// Register offsets, field positions, reset values and keys of the supply monitor
`ifndef LVD_DEFS_SVH
`define LVD_DEFS_SVH

// Register byte offsets on the APB bus
`define LVD_OFF_CTRL        8'h00
`define LVD_OFF_UNLOCK      8'h04
`define LVD_OFF_STATUS      8'h08
`define LVD_OFF_MASK        8'h0C

// detector_control fields
`define LVD_CTRL_LVL_LSB    0
`define LVD_CTRL_LVL_MSB    3
`define LVD_CTRL_PWR_BIT    4
`define LVD_CTRL_STB_BIT    5
`define LVD_CTRL_WIDTH      8

// Status and mask fields (same layout)
`define LVD_STAT_FLAG_BIT   0

// Mask register extra field
`define LVD_MASK_GIE_BIT    1

// Reset values
`define LVD_RST_LEVEL       4'h5
`define LVD_RST_PWR         1'b0

// Trip level codes
`define LVD_LVL_HIGHEST     4'hD

// Unlock keys
`define LVD_KEY_FIRST       8'h55
`define LVD_KEY_SECOND      8'hAA

// Synchroniser depth
`define LVD_SYNC_STAGES     2

`endif

//--- pkg/lvd_pkg.sv
// Types shared by the supply monitor control logic
package lvd_pkg;

	typedef enum logic [1:0] {
		LVD_LOCKED,
		LVD_GOT_FIRST,
		LVD_OPEN
	} lvd_unlock_t;

	typedef logic [3:0] lvd_level_t;

endpackage : lvd_pkg

//--- pkg/lvd_sense_if.sv
// Synchronised analog indications passed from the synchroniser to the control logic
`timescale 1ns/10ps
interface lvd_sense_if;
	logic cmp_below;
	logic ref_stable;

	modport src (output cmp_below, output ref_stable);
	modport dst (input  cmp_below, input  ref_stable);
endinterface : lvd_sense_if

//--- design/lvd_sync.sv
// Two-stage synchroniser for the comparator and reference-stable inputs
`timescale 1ns/10ps
`include "lvd_defs.svh"
module lvd_sync #(
	parameter int STAGES = `LVD_SYNC_STAGES
) (
	// Clock and reset
	input  wire logic i_mclk,
	input  wire logic i_nrst,
	// Raw analog indications
	input  wire logic i_cmp_below,
	input  wire logic i_ref_stable,
	// Synchronised outputs
	lvd_sense_if.src  sense
);

	logic [1:0] raw;
	logic [1:0] sync_q [STAGES];

	assign raw = {i_ref_stable, i_cmp_below};

	genvar g;
	generate
		for (g = 0; g < STAGES; g++) begin : g_stage
			always_ff @(posedge i_mclk or negedge i_nrst) begin
				if (!i_nrst) begin
					sync_q[g] <= 2'h0;
				end else if (g == 0) begin
					sync_q[g] <= raw;
				end else begin
					sync_q[g] <= sync_q[(g == 0) ? 0 : g - 1];
				end
			end
		end
	endgenerate

	assign sense.cmp_below  = sync_q[STAGES-1][0];
	assign sense.ref_stable = sync_q[STAGES-1][1];

endmodule : lvd_sync

//--- design/lvd_ctrl.sv
// Supply monitor control: APB registers, flag, interrupt and wake logic
`timescale 1ns/10ps
`include "lvd_defs.svh"
module lvd_ctrl (
	// Clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_nrst,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Analog side
	input  wire logic        i_cmp_below,
	input  wire logic        i_ref_stable,
	output logic             o_det_power_en,
	output logic      [3:0]  o_trip_level_sel,
	// Core side
	input  wire logic        i_sleep,
	output logic             o_irq,
	output logic             o_wake,
	output logic             o_wake_to_vector
);

	lvd_sense_if sense ();

	// Control and interrupt state
	lvd_pkg::lvd_level_t  level_q;
	logic                 power_en_q;
	logic                 flag_q;
	logic                 irq_en_q;
	logic                 gie_q;
	lvd_pkg::lvd_unlock_t unlock_q;

	// Bus decode
	logic        setup;
	logic        wr_acc;
	logic        hit_ctrl;
	logic        hit_unlock;
	logic        hit_status;
	logic        hit_mask;
	logic        mapped;
	logic        ctrl_wr_ok;
	logic        flag_set;
	logic        flag_clr;
	logic [31:0] rdata_d;
	logic [7:0]  ctrl_view;
	logic        rd_setup;
	logic        level_ok;
	logic        stable_view;
	logic        flag_rise;
	logic        cmp_below_s;
	logic        ref_stable_s;

	lvd_sync #(
		.STAGES (`LVD_SYNC_STAGES)
	) u_sync (
		.i_mclk       (i_mclk),
		.i_nrst       (i_nrst),
		.i_cmp_below  (i_cmp_below),
		.i_ref_stable (i_ref_stable),
		.sense        (sense)
	);

	// A write acts only at the edge that completes the access phase, so
	// a master holding penable longer cannot write twice
	assign setup      = i_psel && !i_penable;
	assign wr_acc     = i_psel && i_penable && o_pready && i_pwrite;
	assign hit_ctrl   = (i_paddr == `LVD_OFF_CTRL);
	assign hit_unlock = (i_paddr == `LVD_OFF_UNLOCK);
	assign hit_status = (i_paddr == `LVD_OFF_STATUS);
	assign hit_mask   = (i_paddr == `LVD_OFF_MASK);
	assign mapped     = hit_ctrl || hit_unlock || hit_status || hit_mask;

	// Control write lands only straight after the unlock pair
	assign ctrl_wr_ok = wr_acc && hit_ctrl
		&& (unlock_q == lvd_pkg::LVD_OPEN);

	// Synchronised copies of the analog indications
	assign cmp_below_s  = sense.cmp_below;
	assign ref_stable_s = sense.ref_stable;

	// Reserved trip codes are refused so the divider never sees them
	assign level_ok = i_pwdata[`LVD_CTRL_LVL_MSB:`LVD_CTRL_LVL_LSB]
		<= `LVD_LVL_HIGHEST;

	// Read data is captured only in the setup cycle of a read
	assign rd_setup = setup && !i_pwrite;

	// Stability bit only meaningful while powered: a reference left from
	// an earlier power-up must not look settled
	assign stable_view = power_en_q && ref_stable_s;

	// Control view: bits 7:6 unimplemented and read zero
	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[`LVD_CTRL_LVL_MSB:`LVD_CTRL_LVL_LSB] = level_q;
		ctrl_view[`LVD_CTRL_PWR_BIT] = power_en_q;
		ctrl_view[`LVD_CTRL_STB_BIT] = stable_view;
	end

	// Read data mux
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (hit_ctrl) begin
			rdata_d[7:0] = ctrl_view;
		end else if (hit_unlock) begin
			rdata_d[1:0] = unlock_q;
		end else if (hit_status) begin
			rdata_d[`LVD_STAT_FLAG_BIT] = flag_q;
		end else if (hit_mask) begin
			rdata_d[`LVD_STAT_FLAG_BIT] = irq_en_q;
			rdata_d[`LVD_MASK_GIE_BIT]  = gie_q;
		end
	end

	// Ready: one wait-free access phase after every setup
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_pready <= 1'b0;
		end else begin
			o_pready <= setup;
		end
	end

	// Error answer for addresses outside the register map
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_pslverr <= 1'b0;
		end else begin
			o_pslverr <= setup && !mapped;
		end
	end

	// Read data prepared in setup and held through the access phase;
	// cleared at the end of the first cycle with i_psel low, so old read data stays on the bus until then
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			o_prdata <= rdata_d;
		end else if (!i_psel) begin
			o_prdata <= 32'h0000_0000;
		end
	end

	// Unlock sequence: first key, second key, then one control write.
	// Any write in between, to any address, drops the sequence, and the
	// open state lasts for exactly one write so a runaway loop cannot
	// keep rewriting the detector setup
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			unlock_q <= lvd_pkg::LVD_LOCKED;
		end else if (wr_acc) begin
			unique case (unlock_q)
				lvd_pkg::LVD_LOCKED: begin
					if (hit_unlock && i_pwdata[7:0] == `LVD_KEY_FIRST) begin
						unlock_q <= lvd_pkg::LVD_GOT_FIRST;
					end
				end
				lvd_pkg::LVD_GOT_FIRST: begin
					if (hit_unlock && i_pwdata[7:0] == `LVD_KEY_SECOND) begin
						unlock_q <= lvd_pkg::LVD_OPEN;
					end else begin
						unlock_q <= lvd_pkg::LVD_LOCKED;
					end
				end
				lvd_pkg::LVD_OPEN: begin
					unlock_q <= lvd_pkg::LVD_LOCKED;
				end
				default: begin
					unlock_q <= lvd_pkg::LVD_LOCKED;
				end
			endcase
		end
	end

	// Trip level; reserved codes leave the level unchanged
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			level_q <= `LVD_RST_LEVEL;
		end else if (ctrl_wr_ok && level_ok) begin
			// A refused code still lets the power bit through the write
			level_q <= i_pwdata[`LVD_CTRL_LVL_MSB:`LVD_CTRL_LVL_LSB];
		end
	end

	// Detector power
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			power_en_q <= `LVD_RST_PWR;
		end else if (ctrl_wr_ok) begin
			power_en_q <= i_pwdata[`LVD_CTRL_PWR_BIT];
		end
	end

	// Flag: set while powered and below trip; set beats write-one clear.
	// Spurious sets while the reference settles are expected; software
	// clears them once the stable bit reads one
	assign flag_set = power_en_q && cmp_below_s;
	assign flag_clr = wr_acc && hit_status && i_pwdata[`LVD_STAT_FLAG_BIT];

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			flag_q <= 1'b0;
		end else if (flag_set) begin
			flag_q <= 1'b1;
		end else if (flag_clr) begin
			flag_q <= 1'b0;
		end
	end

	// Individual enable, same bit position as the flag
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			irq_en_q <= 1'b0;
		end else if (wr_acc && hit_mask) begin
			irq_en_q <= i_pwdata[`LVD_STAT_FLAG_BIT];
		end
	end

	// Global enable; it also decides where a wake-up resumes
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			gie_q <= 1'b0;
		end else if (wr_acc && hit_mask) begin
			gie_q <= i_pwdata[`LVD_MASK_GIE_BIT];
		end
	end

	// Detector power follows the control bit one cycle later
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_det_power_en <= 1'b0;
		end else begin
			o_det_power_en <= power_en_q;
		end
	end

	// Trip code to the divider tap selector
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_trip_level_sel <= `LVD_RST_LEVEL;
		end else begin
			o_trip_level_sel <= level_q;
		end
	end

	// Level interrupt while the flag is set and both enables are on;
	// clearing either enable drops it on the next cycle
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= flag_q && irq_en_q && gie_q;
		end
	end

	// A fresh set is the cycle the flag goes from clear to set; a flag
	// already pending does not wake the core a second time
	assign flag_rise = flag_set && !flag_q;

	// Wake pulse only while the core sleeps
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_wake <= 1'b0;
		end else begin
			o_wake <= i_sleep && flag_rise;
		end
	end

	// Resume at the vector only with interrupts globally enabled
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_wake_to_vector <= 1'b0;
		end else begin
			o_wake_to_vector <= i_sleep && flag_rise && gie_q;
		end
	end

endmodule : lvd_ctrl

//--- test/lvd_ctrl_sva.sv
// Port assertions of the supply monitor control
`timescale 1ns/10ps
module lvd_ctrl_sva (
	// Clock, reset and bus
	input wire logic        i_mclk,
	input wire logic        i_nrst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	// Analog and core side
	input wire logic        i_sleep,
	input wire logic        o_det_power_en,
	input wire logic [3:0]  o_trip_level_sel,
	input wire logic        o_wake,
	input wire logic        o_wake_to_vector
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_ctrl_read;
		o_pready && !i_pwrite && i_paddr == 8'h00;
	endsequence
	chk_apb_answer: assert property (s_setup ##1 i_penable |-> o_pready)
		else $error("no ready in access cycle");
	chk_ready_once: assert property (o_pready |=> !o_pready)
		else $error("ready held");
	chk_level_legal: assert property (o_trip_level_sel <= 4'hd)
		else $error("reserved trip level");
	chk_ctrl_read: assert property (s_ctrl_read |->
		o_prdata[31:6] == 0 && (!o_prdata[5] || o_det_power_en))
		else $error("bad control read");
	chk_wake_pulse: assert property (o_wake |=> !o_wake)
		else $error("wake too long");
	chk_wake_sleep: assert property (o_wake |-> $past(i_sleep))
		else $error("wake while awake");
	chk_vector_wake: assert property (o_wake_to_vector |-> o_wake)
		else $error("vector without wake");
	chk_reset_state: assert property ($rose(i_nrst) |->
		!o_det_power_en && o_trip_level_sel == 4'h5)
		else $error("bad reset state");
endmodule : lvd_ctrl_sva

//--- test/lvd_analog_model.sv
// Behavioural comparator, divider and reference
`timescale 1ns/10ps
module lvd_analog_model #(
	parameter int SETTLE = 4
) (
	input  wire logic       i_mclk,
	input  wire logic       i_power_en,
	input  wire logic [3:0] i_level,
	input  wire logic [3:0] i_supply,
	output logic            o_below,
	output logic            o_stable
);
	int cnt = 0;
	// Reference settles only while powered
	always @(posedge i_mclk) begin
		cnt <= i_power_en ? cnt + 1 : 0;
	end
	assign o_stable = cnt >= SETTLE;
	assign o_below  = i_power_en && i_supply < i_level;
endmodule : lvd_analog_model

//--- test/low_voltage_detect_ctrl_test.sv
// Self-checking bench of the supply monitor control
`timescale 1ns/10ps
module low_voltage_detect_ctrl_test;
	logic        i_mclk = 0, i_nrst = 0;
	logic        psel = 0, pen = 0, pwr = 0, slp = 0;
	logic [7:0]  addr = 0;
	logic [31:0] wdat = 0, rd, prdata;
	logic [3:0]  sup = 4'hf, lvl;
	logic        rdy, serr, below, stb, pwen, irq, wake, vec, rs;
	int          err_total = 0, comparisons = 0;
	lvd_ctrl u_lvd_ctrl (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat),
		.o_prdata(prdata), .o_pready(rdy), .o_pslverr(serr),
		.i_cmp_below(below), .i_ref_stable(stb), .o_det_power_en(pwen),
		.o_trip_level_sel(lvl), .i_sleep(slp), .o_irq(irq), .o_wake(wake),
		.o_wake_to_vector(vec));
	lvd_analog_model u_lvd_analog_model (.i_mclk(i_mclk),
		.i_power_en(pwen), .i_level(lvl), .i_supply(sup),
		.o_below(below), .o_stable(stb));
	initial forever #10 i_mclk = ~i_mclk;
	initial begin
		#200000;
		err_total++;
		print_verdict();
	end
	task automatic ck(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %0t: saw %h expected %h", $time, s, e);
		end
	endtask : ck
	task automatic print_verdict();
		$display("mismatches %0d of %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_mclk);
		psel <= 1'b1;
		pwr <= w;
		addr <= a;
		wdat <= d;
		@(posedge i_mclk);
		pen <= 1'b1;
		do begin
			@(posedge i_mclk);
			n++;
		end while (rdy !== 1'b1 && n < 20);
		rd = prdata;
		rs = serr;
		if (rdy !== 1'b1) begin
			err_total++;
			$display("ERROR %0t: no ready", $time);
		end
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic ctl(input logic [31:0] d);
		apb(1, 8'h04, 8'h55);
		apb(1, 8'h04, 8'haa);
		apb(1, 8'h00, d);
		@(posedge i_mclk);
		@(negedge i_mclk);
	endtask : ctl
	task automatic t_reset();
		apb(0, 8'h00, 0);
		ck(rd, 32'h0000_0005);
		ck({pwen, lvl}, 5'h05);
		apb(0, 8'h08, 0);
		ck(rd, 32'h0000_0000);
	endtask : t_reset
	task automatic t_lock();
		apb(1, 8'h00, 8'h13);
		apb(1, 8'h04, 8'h55);
		apb(1, 8'h08, 0);
		apb(1, 8'h04, 8'haa);
		apb(1, 8'h00, 8'h13);
		@(posedge i_mclk);
		@(negedge i_mclk);
		ck({pwen, lvl}, 5'h05);
	endtask : t_lock
	task automatic t_levels();
		logic [3:0] e;
		e = 4'h5;
		for (int c = 0; c < 16; c++) begin
			ctl(c);
			if (c <= 13) e = c[3:0];
			ck(lvl, e);
		end
	endtask : t_levels
	task automatic t_flag();
		ctl(8'h03);
		ctl(8'h13);
		ck(pwen, 1'b1);
		repeat (12) @(posedge i_mclk);
		apb(0, 8'h00, 0);
		ck(rd, 8'h33);
		@(posedge i_mclk);
		sup <= 4'h2;
		repeat (6) @(posedge i_mclk);
		apb(0, 8'h08, 0);
		ck(rd, 1'b1);
		ck(irq, 1'b0);
		sup <= 4'h9;
		repeat (4) @(posedge i_mclk);
		apb(1, 8'h08, 1);
		apb(0, 8'h08, 0);
		ck(rd, 1'b0);
		apb(1, 8'h0c, 3);
		@(posedge i_mclk);
		sup <= 4'h1;
		repeat (6) @(negedge i_mclk);
		ck(irq, 1'b1);
		apb(1, 8'h0c, 1);
		repeat (2) @(negedge i_mclk);
		ck(irq, 1'b0);
	endtask : t_flag
	task automatic t_sleep(input logic g);
		int n;
		@(posedge i_mclk);
		sup <= 4'h9;
		repeat (4) @(posedge i_mclk);
		apb(1, 8'h08, 1);
		apb(1, 8'h0c, {g, 1'b0});
		@(posedge i_mclk);
		slp <= 1'b1;
		sup <= 4'h1;
		n = 0;
		do begin
			@(negedge i_mclk);
			n++;
		end while (wake !== 1'b1 && n < 20);
		ck(wake, 1'b1);
		ck(vec, g);
		@(posedge i_mclk);
		slp <= 1'b0;
	endtask : t_sleep
	initial begin
		repeat (6) @(posedge i_mclk);
		i_nrst <= 1'b1;
		t_reset();
		t_lock();
		t_levels();
		t_flag();
		t_sleep(1'b1);
		t_sleep(1'b0);
		ctl(8'h03);
		ck(pwen, 1'b0);
		apb(0, 8'h10, 0);
		ck({rs, rd[7:0]}, 9'h100);
		@(posedge i_mclk);
		i_nrst <= 1'b0;
		@(posedge i_mclk);
		i_nrst <= 1'b1;
		t_reset();
		print_verdict();
	end
endmodule : low_voltage_detect_ctrl_test
bind lvd_ctrl lvd_ctrl_sva u_lvd_ctrl_sva (.i_mclk(i_mclk),
	.i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata),
	.o_pready(o_pready), .i_sleep(i_sleep),
	.o_det_power_en(o_det_power_en),
	.o_trip_level_sel(o_trip_level_sel), .o_wake(o_wake),
	.o_wake_to_vector(o_wake_to_vector));
